// File: slm_host_model.sv
/*
 host model driving the three-wire load port.
 assumes send is called from a process synced to core_clk.
*/
`timescale 1ns/10ps
module slm_host_model
(
   input  wire logic core_clk,
   output logic      serial_clk,
   output logic      serial_data,
   output logic      load_strobe
);
   initial
   begin
      serial_clk  = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end
   // 4 cycles a phase, margin over the 3 cycle minimum
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--)
      begin
         @(posedge core_clk) serial_data <= w[i];
         repeat (4) @(posedge core_clk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge core_clk);
         serial_clk <= 1'b0;
      end
      repeat (3) @(posedge core_clk);
      load_strobe <= 1'b1;
      repeat (4) @(posedge core_clk);
      load_strobe <= 1'b0;
      serial_data <= ~w[0]; // released line must not keep last bit
   endtask
endmodule

// File: slm_latch_bank.sv
/*
 serial configuration latches, power-down sequencing and band select
 timing of an integer-n synthesizer. assumes the serial clock, data,
 load strobe, chip enable and reference divider output arrive
 asynchronously and are much slower than core_clk.
*/
`timescale 1ns/10ps

module slm_latch_bank
   import slm_pkg::*;
(
   input  wire logic      core_clk,
   input  wire logic      reset_n,
   input  wire logic      serial_clk,
   input  wire logic      serial_data,
   input  wire logic      load_strobe,
   input  wire logic      chip_enable,
   input  wire logic      ref_div_out,
   output slm_ctrl_s      control_latch,
   output slm_fdiv_s      feedback_divider_latch,
   output slm_rdiv_s      reference_divider_latch,
   output logic           pump_gain_sel,
   output logic           powered_down,
   output logic           bias_settling,
   output logic           band_select_busy,
   output slm_pd_s        pd_effects
);

   // pins: serial clk, data, strobe, enable, ref output
   logic [4:0]          sync1;
   logic [4:0]          sync2;
   logic [4:0]          next_sync1;
   logic [4:0]          next_sync2;
   logic [2:0]          prev_edge;
   logic [2:0]          next_prev_edge;
   logic [WORD_W-1:0]   shift_reg;
   logic [WORD_W-1:0]   next_shift_reg;
   slm_ctrl_s           next_control;
   slm_fdiv_s           next_feedback;
   slm_rdiv_s           next_reference;
   logic                next_pump_gain;
   slm_pwr_e            pwr_state;
   slm_pwr_e            next_pwr_state;
   logic [1:0]          sync_edges;
   logic [1:0]          next_sync_edges;
   logic                next_bias_settling;
   logic                next_band_busy;
   logic [2:0]          band_count;
   logic [2:0]          next_band_count;
   logic [2:0]          band_div;
   logic [2:0]          next_band_div;
   logic [2:0]          band_div_max;
   logic                sclk_rise;
   logic                load_rise;
   logic                ref_rise;
   logic                ce_high;
   logic                ref_tick;
   logic [WORD_W-1:0]   word;
   slm_ctrl_s           word_ctrl;
   slm_fdiv_s           word_fdiv;

   assign sclk_rise = sync2[0] & ~prev_edge[0];
   assign load_rise = sync2[2] & ~prev_edge[1];
   assign ref_rise  = sync2[4] & ~prev_edge[2];
   assign ce_high   = sync2[3];
   // serial register shifts on the core clock, so it stays alive in power-down
   assign word      = shift_reg;
   // field views keep bit positions in the package structs, select bits included at word[1:0]
   assign word_ctrl = slm_ctrl_s'(word);
   assign word_fdiv = slm_fdiv_s'(word);
   // a held divider produces no reference output edges
   assign ref_tick  = ref_rise & ~pd_effects.divider_hold;
   assign band_div_max = 3'((4'h1 << reference_divider_latch.band_clock_div)
                            - 4'h1);

   always_comb
   begin
      next_sync1      = {ref_div_out, chip_enable, load_strobe,
                         serial_data, serial_clk};
      next_sync2      = sync1;
      next_prev_edge  = {sync2[4], sync2[2], sync2[0]};
      next_shift_reg  = shift_reg;
      next_control    = control_latch;
      next_feedback   = feedback_divider_latch;
      next_reference  = reference_divider_latch;
      next_pump_gain  = pump_gain_sel;
      next_pwr_state  = pwr_state;
      next_sync_edges = sync_edges;
      next_bias_settling = bias_settling;
      next_band_busy  = band_select_busy;
      next_band_count = band_count;
      next_band_div   = band_div;

      // data and clock see equal sync delay, so data is sampled aligned
      if (sclk_rise)
      begin
         next_shift_reg = {shift_reg[WORD_W-2:0], sync2[1]};
      end

      if (pwr_state == PWR_SYNC_WAIT && ref_tick)
      begin
         next_sync_edges = sync_edges + 2'h1;
         if (sync_edges + 2'h1 == SYNC_PD_EDGES)
         begin
            next_pwr_state = PWR_DOWN;
         end
      end

      if (band_select_busy && !powered_down && ref_tick)
      begin
         next_band_div = band_div + 3'h1;
         if (band_div == band_div_max)
         begin
            next_band_div   = 3'h0;
            next_band_count = band_count + 3'h1;
            if (band_count + 3'h1 == BAND_CYCLES)
            begin
               next_band_busy = 1'b0;
            end
         end
      end

      if (load_rise)
      begin
         case (word[1:0])
            SEL_CONTROL:
            begin
               next_control   = word_ctrl;
               next_pump_gain = word_ctrl.pump_gain_sel;
               if (!word_ctrl.power_down_request)
               begin
                  next_pwr_state = PWR_ACTIVE;
                  if (pwr_state == PWR_UNPROGRAMMED)
                  begin
                     next_bias_settling = 1'b1;
                  end
               end
               else if (!word_ctrl.power_down_sync_select)
               begin
                  next_pwr_state = PWR_DOWN;
               end
               else if (pwr_state == PWR_ACTIVE)
               begin
                  next_pwr_state  = PWR_SYNC_WAIT;
                  next_sync_edges = 2'h0;
               end
            end
            SEL_REFERENCE:
            begin
               next_reference = slm_rdiv_s'(word);
            end
            SEL_FEEDBACK:
            begin
               next_feedback      = word_fdiv;
               next_pump_gain     = word_fdiv.pump_gain_sel;
               next_bias_settling = 1'b0;
               // only a divider update starts band selection; power-up
               // keeps the retained band
               next_band_busy  = 1'b1;
               next_band_count = 3'h0;
               next_band_div   = 3'h0;
            end
            SEL_TEST:
            begin
               // factory test latch is not implemented; word dropped
               next_shift_reg = shift_reg;
            end
            default:
            begin
               next_shift_reg = shift_reg;
            end
         endcase
      end
   end

   always_comb
   begin
      powered_down = ~ce_high
                     | (pwr_state == PWR_DOWN)
                     | (pwr_state == PWR_UNPROGRAMMED);
      pd_effects.divider_hold      = powered_down
                                     | control_latch.divider_reset_bit;
      pd_effects.pump_hiz          = powered_down
                                     | control_latch.pump_tristate;
      pd_effects.lock_detect_clear = powered_down;
      pd_effects.outputs_hiz       = powered_down;
      pd_effects.ref_buffer_off    = powered_down;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         sync1            <= 5'h00;
         sync2            <= 5'h00;
         prev_edge        <= 3'h0;
         shift_reg        <= LATCH_RESET;
         control_latch    <= slm_ctrl_s'(LATCH_RESET);
         feedback_divider_latch  <= slm_fdiv_s'(LATCH_RESET);
         reference_divider_latch <= slm_rdiv_s'(LATCH_RESET);
         pump_gain_sel    <= 1'b0;
         pwr_state        <= PWR_UNPROGRAMMED;
         sync_edges       <= 2'h0;
         bias_settling    <= 1'b0;
         band_select_busy <= 1'b0;
         band_count       <= 3'h0;
         band_div         <= 3'h0;
      end
      else
      begin
         sync1            <= next_sync1;
         sync2            <= next_sync2;
         prev_edge        <= next_prev_edge;
         shift_reg        <= next_shift_reg;
         control_latch    <= next_control;
         feedback_divider_latch  <= next_feedback;
         reference_divider_latch <= next_reference;
         pump_gain_sel    <= next_pump_gain;
         pwr_state        <= next_pwr_state;
         sync_edges       <= next_sync_edges;
         bias_settling    <= next_bias_settling;
         band_select_busy <= next_band_busy;
         band_count       <= next_band_count;
         band_div         <= next_band_div;
      end
   end

endmodule

// File: slm_latch_bank_checker.sv
/*
 port assertions of the latch bank.
 assumes binding onto slm_latch_bank, one core_clk domain.
*/
`timescale 1ns/10ps
module slm_latch_bank_checker
   import slm_pkg::*;
(
   input wire logic      core_clk,
   input wire logic      reset_n,
   input wire logic      load_strobe,
   input wire logic      chip_enable,
   input wire slm_ctrl_s control_latch,
   input wire slm_fdiv_s feedback_divider_latch,
   input wire slm_rdiv_s reference_divider_latch,
   input wire logic      pump_gain_sel,
   input wire logic      powered_down,
   input wire logic      bias_settling,
   input wire logic      band_select_busy,
   input wire slm_pd_s   pd_effects
);
   wire slm_ctrl_s c = control_latch;
   wire slm_fdiv_s f = feedback_divider_latch;
   wire slm_rdiv_s r = reference_divider_latch;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // strobe is held 4 cycles, so depth 2 sits inside it
   AST_CTRL_LOAD: assert property ($changed(c) |->
      $past(load_strobe, 2) && c.latch_select == SEL_CONTROL)
      else $error("control latch changed without control load");
   AST_FDIV_LOAD: assert property ($changed(f) |->
      $past(load_strobe, 2) && f.latch_select == SEL_FEEDBACK)
      else $error("feedback latch changed without feedback load");
   AST_RDIV_LOAD: assert property ($changed(r) |->
      $past(load_strobe, 2) && r.latch_select == SEL_REFERENCE)
      else $error("reference latch changed without reference load");
   AST_GAIN: assert property ($changed(c) || $changed(f) |->
      pump_gain_sel == ($changed(f) ? f.pump_gain_sel : c.pump_gain_sel))
      else $error("pump gain not from latest write");
   AST_BAND: assert property ($changed(f) |->
      band_select_busy && !bias_settling)
      else $error("feedback load did not start band selection");
   AST_ASYNC_PD: assert property ($changed(c) &&
      c.power_down_request && !c.power_down_sync_select |-> powered_down)
      else $error("immediate power-down missed");
   AST_SYNC_PD: assert property ($changed(c) &&
      c.power_down_request && c.power_down_sync_select &&
      !$past(powered_down) |-> !powered_down)
      else $error("synchronous power-down did not wait");
   AST_CE: assert property (!chip_enable [*4] |-> powered_down)
      else $error("chip enable low left device running");
   AST_PD_FX: assert property (powered_down |-> &pd_effects)
      else $error("power-down effects incomplete");
   AST_CRESET: assert property (c.divider_reset_bit |->
      pd_effects.divider_hold)
      else $error("counter reset bit did not hold dividers");
endmodule
bind slm_latch_bank slm_latch_bank_checker u_chk (.*);

// File: slm_pkg.sv
/*
 package of the synthesizer latch bank: word layout, latch select codes,
 power states and sequencing counts. assumes nothing of its users.
*/
package slm_pkg;

   localparam int WORD_W = 24;

   localparam logic [1:0] SEL_CONTROL   = 2'h0;
   localparam logic [1:0] SEL_REFERENCE = 2'h1;
   localparam logic [1:0] SEL_FEEDBACK  = 2'h2;
   localparam logic [1:0] SEL_TEST      = 2'h3;

   localparam logic [23:0] LATCH_RESET     = 24'h000000;
   localparam logic [2:0]  BAND_CYCLES     = 3'h5;
   localparam logic [1:0]  SYNC_PD_EDGES   = 2'h2;

   typedef struct packed {
      logic [1:0] prescaler_select;
      logic       power_down_sync_select;
      logic       power_down_request;
      logic [2:0] pump_current_two;
      logic [2:0] pump_current_one;
      logic [1:0] output_power_sel;
      logic       mute_until_lock;
      logic       pump_gain_sel;
      logic       pump_tristate;
      logic       detector_polarity;
      logic [2:0] monitor_sel;
      logic       divider_reset_bit;
      logic [1:0] core_power_sel;
      logic [1:0] latch_select;
   } slm_ctrl_s;

   typedef struct packed {
      logic        half_rate_prescaler_feed;
      logic        half_rate_output;
      logic        pump_gain_sel;
      logic [12:0] b_count;
      logic        spare_bit;
      logic [4:0]  a_count;
      logic [1:0]  latch_select;
   } slm_fdiv_s;

   typedef struct packed {
      logic [1:0]  spare_bits;
      logic [1:0]  band_clock_div;
      logic        factory_test_bit;
      logic        lock_window_count;
      logic [1:0]  antibacklash_width;
      logic [13:0] ref_count;
      logic [1:0]  latch_select;
   } slm_rdiv_s;

   typedef struct packed {
      logic divider_hold;
      logic pump_hiz;
      logic lock_detect_clear;
      logic outputs_hiz;
      logic ref_buffer_off;
   } slm_pd_s;

   typedef enum logic [3:0] {
      PWR_UNPROGRAMMED = 4'h1,
      PWR_ACTIVE       = 4'h2,
      PWR_SYNC_WAIT    = 4'h4,
      PWR_DOWN         = 4'h8
   } slm_pwr_e;

endpackage

// File: tb_slm_latch_bank.sv
/*
 self-checking bench of the latch bank driven through the host model.
 assumes slm_pkg, the host model and the checker compile first.
*/
`timescale 1ns/10ps
module tb_slm_latch_bank;
   import slm_pkg::*;
   localparam int SETTLE = 1500; // shortened, the bank does not time it
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        chip_enable = 1'b1;
   logic        ref_div_out = 1'b0;
   logic        serial_clk, serial_data, load_strobe;
   slm_ctrl_s   control_latch;
   slm_fdiv_s   feedback_divider_latch;
   slm_rdiv_s   reference_divider_latch;
   logic        pump_gain_sel, powered_down, bias_settling, band_select_busy;
   slm_pd_s     pd_effects;
   logic [72:0] exp_q[$];
   logic [72:0] shadow = '0;
   logic [23:0] w, c;
   integer      seed = 18713;
   int          miscompares = 0, cmp_count = 0, rises = 0, i;
   wire  [72:0] seen = {control_latch, feedback_divider_latch,
                        reference_divider_latch, pump_gain_sel};
   slm_latch_bank dut (.*);
   slm_host_model host (.*);
   always #2 core_clk = ~core_clk;
   always
   begin
      repeat (20) @(posedge core_clk);
      ref_div_out <= ~ref_div_out;
   end
   always @(posedge ref_div_out) rises++;
   always @(posedge load_strobe) rises = 0;
   task automatic chk(input string n, input logic [72:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic load(input logic [23:0] v);
      case (v[1:0])
         SEL_CONTROL:   shadow = {v, shadow[48:1], v[10]};
         SEL_REFERENCE: shadow[24:1] = v;
         SEL_FEEDBACK:  shadow = {shadow[72:49], v, shadow[24:1], v[21]};
         default:       ; // test code leaves all latches alone
      endcase
      exp_q.push_back(shadow);
      host.send(v);
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   always @(posedge load_strobe)
   begin
      repeat (5) @(posedge core_clk);
      #1;
      chk("latch", seen, exp_q.pop_front());
   end
   initial
   begin
      #200000;
      miscompares++;
      final_report();
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      #1;
      chk("reset", {powered_down, pd_effects}, 6'h3F);
      w = $random(seed);
      // band clock divided by two, so the band divider path runs
      load({2'h0, 2'h1, 1'b0, w[18:2], SEL_REFERENCE});
      c = $random(seed);
      c[21:20] = 2'h0;
      c[4] = 1'b0;
      c[1:0] = SEL_CONTROL;
      load(c);
      chk("settle", {powered_down, bias_settling}, 2'h1);
      repeat (SETTLE) @(posedge core_clk);
      // strobe then lands mid reference period, so edges count cleanly
      @(posedge ref_div_out);
      w = $random(seed);
      w[1:0] = SEL_FEEDBACK;
      load(w);
      chk("band", {band_select_busy, bias_settling}, 2'h2);
      for (i = 0; i < 600 && band_select_busy !== 1'b0; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      chk("band end", band_select_busy, 1'b0);
      // five band clocks of two reference edges each
      chk("band cycles", rises, 73'hA);
      w = $random(seed);
      w[1:0] = SEL_TEST;
      load(w);
      $display("programming test done");
      c[21:20] = 2'h1;
      load(c);
      chk("async pd", {powered_down, pd_effects}, 6'h3F);
      // feedback latch left untouched while down
      w = $random(seed);
      load({5'h00, w[18:2], SEL_REFERENCE});
      c[21:20] = 2'h0;
      c[10] = ~c[10];
      load(c);
      chk("wake", {powered_down, band_select_busy}, 2'h0);
      chk("active fx", pd_effects, {c[4], c[9], 3'h0});
      $display("async power-down test done");
      @(posedge ref_div_out); // strobe lands mid reference period
      c[21:20] = 2'h3;
      load(c);
      chk("sync wait", powered_down, 1'b0);
      for (i = 0; i < 300 && powered_down !== 1'b1; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      chk("sync edges", rises, 73'h2);
      c[21:20] = 2'h0;
      load(c);
      @(posedge core_clk) chip_enable <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      chk("ce low", powered_down, 1'b1);
      @(posedge core_clk) chip_enable <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      chk("ce high", powered_down, 1'b0);
      $display("power-down tests done");
      c[4] = 1'b1;
      load(c);
      chk("count hold", pd_effects.divider_hold, 1'b1);
      $display("counter reset test done");
      final_report();
   end
endmodule
